/* hdl/acc_ctrl.sv */
// Purpose: conversion control: starts, triggers, result lock and alignment
// Assumes: register writes arrive as one-cycle strobes with data ports
// Notes:   analog front end sits outside; only its selects, power, trial code and comparator are seen
`timescale 1ns/100ps
`include "acc_cfg.svh"
// Behaviour
// R1: result is 10 bits over two bytes, right or left aligned by select bit
// R2: software reads low byte then high, or high only if left aligned
// R3: reading low byte blocks result updates until high byte is read
// R4: completion while blocked leaves both bytes unchanged, result dropped
// R5: reading high byte re-enables result updates
// R6: completion flag still sets when the result was dropped
// R7: reference and channel reach the converter only while enabled
// R8: converter works only while power reduction bit is zero
// R9: start bit begins one conversion, stays set, cleared on completion
// R10: channel change during conversion waits for current conversion to finish
// R11: auto trigger enable plus source select choose trigger signal
// R12: rising trigger edge restarts prescaler and starts a conversion
// R13: trigger still high at completion starts nothing; new edge needed
// R14: trigger edges during a conversion are ignored
// R15: trigger flags set regardless of interrupt enables; software clears them
// R16: own completion flag as source gives free running conversions
// R17: writing start bit still starts one conversion under auto trigger
// R18: start bit reads one during every conversion
// R19: input select picks eight channels, ground or bandgap
// R20: code zero at ground, maximum is reference minus one step
// R21: reference select picks external, supply or internal reference
// R22: normal conversion 13 conversion clocks, first after enable 25
// R23: completion writes result, sets flag, clears start bit together
// R24: flag cleared by interrupt service or by writing one
module acc_ctrl #(
    parameter int N_TRIG = 8
) (
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    input  wire logic                    converter_power_reduction_i,
    input  wire logic                    converter_enable_i,
    input  wire logic                    auto_trigger_enable_i,
    input  wire logic [2:0]              trigger_source_select_i,
    input  wire logic [N_TRIG-1:0]       trigger_flags_i,
    input  wire logic                    left_align_select_i,
    input  wire logic [3:0]              input_channel_select_i,
    input  wire logic [1:0]              reference_select_i,
    input  wire logic [`ACC_PRESC_W-1:0] prescale_i,
    input  wire logic                    start_conversion_wr_i,
    input  wire logic                    done_flag_clear_i,
    input  wire logic                    irq_serviced_i,
    input  wire logic                    result_low_rd_i,
    input  wire logic                    result_high_rd_i,
    input  wire logic                    cmp_above_i,
    output logic                         start_conversion_o,
    output logic                         conversion_done_flag_o,
    output logic [7:0]                   result_high_byte_o,
    output logic [7:0]                   result_low_byte_o,
    output logic                         result_locked_o,
    output logic [3:0]                   analog_channel_o,
    output logic [1:0]                   analog_reference_o,
    output logic                         analog_power_o,
    output logic [`ACC_RES_W-1:0]        dac_code_o
);
    // ****************************************************************
    // state and signals
    // ****************************************************************
    acc_pkg::acc_state_e   state_q, state_d;
    acc_conv_if            conv ();
    logic                  trig_prev_q;
    logic                  first_q;
    logic                  lock_q;
    logic [`ACC_RES_W-1:0] result_q;
    logic [3:0]            chan_q;
    logic [1:0]            ref_q;
    logic                  done_q;
    logic                  sc_q;
    logic [`ACC_RES_W-1:0] code;
    logic [`ACC_RES_W-1:0] trial;

    // ****************************************************************
    // decode
    // ****************************************************************
    // power reduction overrides enable so nothing runs while gated
    wire active      = converter_enable_i & ~converter_power_reduction_i; // R8
    wire free_run    = trigger_source_select_i == `ACC_TRIG_FREE;
    // free running watches our own completion pulse, not the flag level
    wire trig_level  = free_run ? conv.done
                                : trigger_flags_i[trigger_source_select_i]; // R11 R15
    wire trig_rise   = trig_level & ~trig_prev_q; // R13
    wire auto_start  = active & auto_trigger_enable_i & trig_rise; // R12 R16
    wire sw_start    = active & start_conversion_wr_i; // R9 R17
    wire idle        = state_q != acc_pkg::ACC_BUSY;
    wire go          = idle & (sw_start | auto_start) & ~conv.done; // R14
    wire go_free     = active & auto_trigger_enable_i & free_run & conv.done & sc_q; // R16
    wire start_pulse = go | go_free;
    wire [15:0]           packed_res = left_align_select_i ? {result_q, 6'h00}
                                                           : {6'h00, result_q}; // R1

    assign conv.start  = start_pulse;
    assign conv.first  = first_q;

    // ****************************************************************
    // state machine
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            acc_pkg::ACC_IDLE: begin
                // a start on the enabling edge must still mark the block busy
                if (active) state_d = start_pulse ? acc_pkg::ACC_BUSY : acc_pkg::ACC_ARMED;
            end
            acc_pkg::ACC_ARMED: begin
                if (!active) state_d = acc_pkg::ACC_IDLE;
                else if (start_pulse) state_d = acc_pkg::ACC_BUSY;
            end
            acc_pkg::ACC_BUSY: begin
                if (!active) state_d = acc_pkg::ACC_IDLE;
                else if (conv.done && !go_free) state_d = acc_pkg::ACC_ARMED;
            end
            default: state_d = acc_pkg::ACC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q     <= acc_pkg::ACC_IDLE;
            trig_prev_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            trig_prev_q <= trig_level;
        end
    end

    // first conversion after enabling is the long one
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            first_q <= 1'b1;
        end else if (!active) begin
            first_q <= 1'b1; // R22
        end else if (start_pulse) begin
            first_q <= 1'b0;
        end
    end

    // ****************************************************************
    // start bit and completion flag
    // ****************************************************************
    // start bit stays high across back-to-back free running conversions
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sc_q <= 1'b0;
        end else if (!active) begin
            sc_q <= 1'b0;
        end else if (start_pulse) begin
            sc_q <= 1'b1; // R9 R18
        end else if (conv.done) begin
            sc_q <= 1'b0; // R23
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            done_q <= 1'b0;
        end else if (conv.done) begin
            done_q <= 1'b1; // R6 R23
        end else if (done_flag_clear_i || irq_serviced_i) begin
            done_q <= 1'b0; // R24
        end
    end

    // ****************************************************************
    // result lock and result register
    // ****************************************************************
    // high read releases even if a low read lands together
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lock_q <= 1'b0;
        end else if (result_high_rd_i) begin
            lock_q <= 1'b0; // R5
        end else if (result_low_rd_i) begin
            lock_q <= 1'b1; // R3
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            result_q <= '0;
        end else if (conv.done && !lock_q) begin
            result_q <= code; // R4 R23
        end
    end

    // ****************************************************************
    // analog selections
    // ****************************************************************
    // selections freeze while busy so a mid-conversion change lands after it
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            chan_q <= `ACC_CH_GROUND;
            ref_q  <= 2'h0;
        end else if (!active) begin
            chan_q <= `ACC_CH_GROUND; // R7
            ref_q  <= 2'h0;
        end else if (state_q != acc_pkg::ACC_BUSY || conv.done) begin
            chan_q <= input_channel_select_i; // R10 R19
            ref_q  <= reference_select_i; // R21
        end
    end

    // ****************************************************************
    // submodules
    // ****************************************************************
    acc_conv_timer u_timer (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .enable_i   (active),
        .prescale_i (prescale_i),
        .conv       (conv.timer)
    );

    acc_sar #(.W(`ACC_RES_W)) u_sar (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .start_i     (start_pulse),
        .tick_i      (conv.tick),
        .cmp_above_i (cmp_above_i),
        .trial_o     (trial),
        .code_o      (code)
    );

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            start_conversion_o     <= 1'b0;
            conversion_done_flag_o <= 1'b0;
            result_high_byte_o     <= 8'h00;
            result_low_byte_o      <= 8'h00;
            result_locked_o        <= 1'b0;
            analog_channel_o       <= `ACC_CH_GROUND;
            analog_reference_o     <= 2'h0;
            analog_power_o         <= 1'b0;
            dac_code_o             <= '0;
        end else begin
            start_conversion_o     <= sc_q;
            conversion_done_flag_o <= done_q;
            result_high_byte_o     <= packed_res[15:8];
            result_low_byte_o      <= packed_res[7:0];
            result_locked_o        <= lock_q;
            analog_channel_o       <= chan_q;
            analog_reference_o     <= ref_q;
            analog_power_o         <= active; // R8
            dac_code_o             <= trial;
        end
    end

endmodule : acc_ctrl

/* hdl/acc_cfg.svh */
// Purpose: constants for the converter conversion control block
// Assumes: 100 MHz system clock
// Notes:   definitions only
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
`define ACC_RES_W          10
`define ACC_NORMAL_CYC     5'd13
`define ACC_FIRST_CYC      5'd25
`define ACC_PRESC_W        7
`define ACC_TRIG_FREE      3'h0
`define ACC_TRIG_CNT_W     3
`define ACC_CH_GROUND      4'hF
`define ACC_CH_BANDGAP     4'hE
`define ACC_CH_EXT_MAX     4'h7
`endif

/* hdl/acc_pkg.sv */
// Purpose: types for the converter conversion control block
// Assumes: nothing
// Notes:   state encodings are one-hot
package acc_pkg;
    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,
        ACC_ARMED = 3'b010,
        ACC_BUSY  = 3'b100
    } acc_state_e;
    typedef enum logic [1:0] {
        ACC_REF_EXTERNAL = 2'h0,
        ACC_REF_SUPPLY   = 2'h1,
        ACC_REF_RESERVED = 2'h2,
        ACC_REF_INTERNAL = 2'h3
    } acc_ref_e;
endpackage : acc_pkg

/* hdl/acc_conv_if.sv */
// Purpose: link between control core and conversion timer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/100ps
interface acc_conv_if;
    logic       start;
    logic       first;
    logic       tick;
    logic       done;
    modport ctrl  (output start, output first, input tick, input done);
    modport timer (input start, input first, output tick, output done);
endinterface : acc_conv_if

/* hdl/acc_conv_timer.sv */
// Purpose: conversion clock prescaler and conversion length counter
// Assumes: start only while idle
// Notes:   prescaler restarts on each start so trigger to sample delay is fixed
`timescale 1ns/100ps
`include "acc_cfg.svh"
module acc_conv_timer (
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    input  wire logic                    enable_i,
    input  wire logic [`ACC_PRESC_W-1:0] prescale_i,
    acc_conv_if.timer                    conv
);
    logic [`ACC_PRESC_W-1:0] presc_q;
    logic [4:0]              cnt_q;
    logic                    run_q;
    logic                    tick_q;
    logic                    done_q;
    wire                     presc_wrap = (presc_q >= prescale_i);

    // prescaler held in reset while disabled or on start
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            presc_q <= '0;
        end else if (!enable_i || conv.start || presc_wrap) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // counts conversion clock cycles of one conversion
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            run_q  <= 1'b0;
            cnt_q  <= 5'd0;
            tick_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            tick_q <= presc_wrap & run_q;
            done_q <= 1'b0;
            if (!enable_i) begin
                run_q <= 1'b0;
            end else if (conv.start) begin
                run_q <= 1'b1;
                cnt_q <= conv.first ? `ACC_FIRST_CYC : `ACC_NORMAL_CYC; // R22
            end else if (run_q && presc_wrap) begin
                cnt_q <= cnt_q - 5'd1;
                if (cnt_q == 5'd1) begin
                    run_q  <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign conv.tick = tick_q;
    assign conv.done = done_q;
endmodule : acc_conv_timer

/* hdl/acc_sar.sv */
// Purpose: successive approximation register, one bit per conversion clock
// Assumes: comparator output valid when tick arrives; needs prescale of one or more
// Notes:   code zero at ground, all ones at reference minus one step
`timescale 1ns/100ps
`include "acc_cfg.svh"
module acc_sar #(
    parameter int W = `ACC_RES_W
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic         start_i,
    input  wire logic         tick_i,
    input  wire logic         cmp_above_i,
    output logic [W-1:0]      trial_o,
    output logic [W-1:0]      code_o
);
    logic [W-1:0] bit_q;

    // binary search, msb first; finished bits stay frozen
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            trial_o <= '0;
            bit_q   <= '0;
        end else if (start_i) begin
            bit_q   <= {1'b1, {(W-1){1'b0}}};
            trial_o <= {1'b1, {(W-1){1'b0}}};
        end else if (tick_i && bit_q != '0) begin
            trial_o <= (cmp_above_i ? trial_o : (trial_o & ~bit_q)) | (bit_q >> 1); // R20
            bit_q   <= bit_q >> 1;
        end
    end
    assign code_o = trial_o;
endmodule : acc_sar

/* tb/acc_ctrl_sva.sv */
// Purpose: port-level checks on the conversion control block
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound to every acc_ctrl instance at the foot of this file
`timescale 1ns/100ps
module acc_ctrl_sva (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       converter_power_reduction_i,
    input wire logic       converter_enable_i,
    input wire logic       auto_trigger_enable_i,
    input wire logic       left_align_select_i,
    input wire logic       start_conversion_wr_i,
    input wire logic       done_flag_clear_i,
    input wire logic       irq_serviced_i,
    input wire logic       result_low_rd_i,
    input wire logic       result_high_rd_i,
    input wire logic       start_conversion_o,
    input wire logic       conversion_done_flag_o,
    input wire logic [7:0] result_high_byte_o,
    input wire logic [7:0] result_low_byte_o,
    input wire logic       result_locked_o,
    input wire logic [3:0] analog_channel_o,
    input wire logic       analog_power_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // alignment is applied live, so byte checks wait for a settled select
    chk_start_taken: assert property (
        start_conversion_wr_i && converter_enable_i && !converter_power_reduction_i && !start_conversion_o
        |-> ##[1:3] start_conversion_o) else $error("start write not taken");
    chk_start_done: assert property (
        $fell(start_conversion_o) && converter_enable_i && $past(converter_enable_i)
        && !converter_power_reduction_i |-> conversion_done_flag_o) else $error("start fell without flag");
    chk_flag_sticky: assert property (
        conversion_done_flag_o && !done_flag_clear_i && !irq_serviced_i && !$past(done_flag_clear_i)
        && !$past(irq_serviced_i) |=> conversion_done_flag_o) else $error("flag dropped unasked");
    chk_lock_set: assert property (
        result_low_rd_i && !result_high_rd_i |-> ##[1:2] result_locked_o) else $error("low read did not lock");
    chk_lock_free: assert property (
        result_high_rd_i && !result_low_rd_i |-> ##[1:2] !result_locked_o) else $error("high read kept lock");
    chk_bytes_frozen: assert property (
        ($stable(left_align_select_i) && result_locked_o)[*3]
        |-> $stable({result_high_byte_o, result_low_byte_o})) else $error("bytes moved while locked");
    chk_bytes_flagged: assert property (
        $stable(left_align_select_i)[*4] ##0 !$stable({result_high_byte_o, result_low_byte_o})
        |-> conversion_done_flag_o) else $error("bytes moved without flag");
    chk_chan_held: assert property (
        $rose(start_conversion_o) && !auto_trigger_enable_i
        |=> $stable(analog_channel_o)[*8]) else $error("channel moved mid conversion");
    chk_power_gate: assert property (
        (!converter_enable_i || converter_power_reduction_i)[*3] |-> !analog_power_o)
        else $error("converter powered while off");

    cover property ($rose(conversion_done_flag_o));
    cover property (result_locked_o && $rose(conversion_done_flag_o));
    cover property (auto_trigger_enable_i && $rose(start_conversion_o));
endmodule : acc_ctrl_sva

bind acc_ctrl acc_ctrl_sva u_sva (.*);

/* tb/tb_acc_ctrl.sv */
// Purpose: self-checking bench for the conversion control block
// Assumes: prescale 1, two system clocks per conversion clock
// Notes:   the bench plays the analog front end through the comparator input
`timescale 1ns/100ps
`include "acc_cfg.svh"
module tb_acc_ctrl;
    // ****************************************
    // signals
    // ****************************************
    logic                    clk_i = 1'b0;
    logic                    reset_i = 1'b1;
    logic                    converter_power_reduction_i = 1'b0;
    logic                    converter_enable_i = 1'b0;
    logic                    auto_trigger_enable_i = 1'b0;
    logic [2:0]              trigger_source_select_i = 3'h0;
    logic [7:0]              trigger_flags_i = 8'h00;
    logic                    left_align_select_i = 1'b0;
    logic [3:0]              input_channel_select_i = 4'h0;
    logic [1:0]              reference_select_i = 2'h0;
    logic [`ACC_PRESC_W-1:0] prescale_i = 7'h01; // tied: fastest rate that leaves time for the comparator loop
    logic                    start_conversion_wr_i = 1'b0;
    logic                    done_flag_clear_i = 1'b0;
    logic                    irq_serviced_i = 1'b0;
    logic                    result_low_rd_i = 1'b0;
    logic                    result_high_rd_i = 1'b0;
    logic                    cmp_above_i = 1'b0;
    logic                    start_conversion_o, conversion_done_flag_o, result_locked_o, analog_power_o;
    logic [7:0]              result_high_byte_o, result_low_byte_o;
    logic [3:0]              analog_channel_o;
    logic [1:0]              analog_reference_o;
    logic [`ACC_RES_W-1:0]   dac_code_o;
    logic [9:0]              vin [16];
    logic [31:0]             lfsr = 32'h338FBCCE;
    logic [15:0]             exp_q [$];
    int                      error_cnt = 0, checks_done = 0, n0, n1;

    acc_ctrl DUT (.*);

    always #5 clk_i = ~clk_i;
    // input sits half a step above vin, so the search settles on vin exactly
    always @(negedge clk_i) cmp_above_i <= (vin[analog_channel_o] >= dac_code_o);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] nxt(input logic [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    function automatic logic [15:0] fmt(input logic [9:0] r, input logic l);
        fmt = l ? {r, 6'h00} : {6'h00, r};
    endfunction : fmt

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask : pulse

    // bounded wait; a hang shows up as a failed flag compare
    task automatic wait_flag(output int n);
        n = 0;
        while (conversion_done_flag_o !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        chk(conversion_done_flag_o, 1'b1);
    endtask : wait_flag

    task automatic clear_flag(input logic by_irq);
        if (by_irq) pulse(irq_serviced_i);
        else pulse(done_flag_clear_i);
        repeat (2) @(negedge clk_i);
        chk(conversion_done_flag_o, 1'b0);
    endtask : clear_flag

    // software-started conversion; the channel select moves to c2 mid-way
    task automatic conv(input logic [3:0] c, input logic l, input logic [3:0] c2, input logic [15:0] e,
                        output int n);
        input_channel_select_i = c;
        left_align_select_i = l;
        exp_q.push_back(e);
        pulse(start_conversion_wr_i);
        repeat (3) @(negedge clk_i);
        chk(start_conversion_o, 1'b1);
        chk(dac_code_o, 10'h200);
        input_channel_select_i = c2;
        repeat (3) @(negedge clk_i);
        chk(analog_channel_o, c);
        wait_flag(n);
        chk({result_high_byte_o, result_low_byte_o}, exp_q.pop_front());
        chk(start_conversion_o, 1'b0);
        clear_flag(c[0]);
        chk(analog_channel_o, c2);
    endtask : conv

    task automatic end_of_test;
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        for (int i = 0; i < 16; i++) begin
            lfsr = nxt(lfsr);
            vin[i] = lfsr[9:0];
        end
        vin[7] = 10'h3FF;
        vin[15] = 10'h000; // ground channel
        repeat (4) @(negedge clk_i);
        reset_i = 1'b0;
        chk({analog_channel_o, analog_power_o, start_conversion_o, conversion_done_flag_o, result_locked_o,
             result_high_byte_o, result_low_byte_o}, 24'hF00000);
        reference_select_i = 2'h3;
        repeat (4) @(negedge clk_i);
        chk({analog_reference_o, analog_power_o}, 3'h0);
        converter_enable_i = 1'b1;
        for (int r = 0; r < 4; r++) begin
            reference_select_i = r[1:0];
            repeat (3) @(negedge clk_i);
            if (r != 2) chk(analog_reference_o, reference_select_i);
        end
        for (int k = 0; k < 16; k++) begin
            if (k < 8 || k > 13) begin
                conv(k[3:0], k[0], k[3:0] ^ 4'h1, fmt(vin[k], k[0]), n1);
                if (k == 0) n0 = n1;
            end
        end
        chk(n0 - n1, (`ACC_FIRST_CYC - `ACC_NORMAL_CYC) * 2);
        // a low read holds the bytes; the completion still flags
        pulse(result_low_rd_i);
        repeat (2) @(negedge clk_i);
        chk(result_locked_o, 1'b1);
        conv(4'h2, 1'b1, 4'h2, fmt(vin[15], 1'b1), n0);
        pulse(result_high_rd_i);
        repeat (2) @(negedge clk_i);
        chk(result_locked_o, 1'b0);
        conv(4'h3, 1'b1, 4'h3, fmt(vin[3], 1'b1), n0);
        // left aligned: a lone high read is legal and leaves nothing locked
        pulse(result_high_rd_i);
        @(negedge clk_i);
        chk(result_locked_o, 1'b0);
        chk(result_high_byte_o, vin[3][9:2]);
        converter_power_reduction_i = 1'b1;
        pulse(start_conversion_wr_i);
        repeat (4) @(negedge clk_i);
        chk({start_conversion_o, analog_power_o}, 2'h0);
        converter_power_reduction_i = 1'b0;
        auto_trigger_enable_i = 1'b1;
        trigger_source_select_i = 3'h3;
        trigger_flags_i[5] = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(start_conversion_o, 1'b0);
        exp_q.push_back(fmt(vin[3], 1'b1));
        trigger_flags_i[3] = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(start_conversion_o, 1'b1);
        trigger_flags_i[3] = 1'b0;
        @(negedge clk_i);
        trigger_flags_i[3] = 1'b1; // second edge lands mid-conversion
        wait_flag(n0);
        chk({result_high_byte_o, result_low_byte_o}, exp_q.pop_front());
        clear_flag(1'b0);
        repeat (5) @(negedge clk_i);
        chk(start_conversion_o, 1'b0);
        trigger_flags_i = 8'h00;
        conv(4'h4, 1'b0, 4'h4, fmt(vin[4], 1'b0), n0);
        // own completion as source: runs on with the flag left set
        trigger_source_select_i = 3'h0;
        exp_q.push_back(fmt(vin[4], 1'b0));
        exp_q.push_back(fmt(vin[4], 1'b0));
        pulse(start_conversion_wr_i);
        wait_flag(n0);
        chk({result_high_byte_o, result_low_byte_o}, exp_q.pop_front());
        repeat (20) @(negedge clk_i);
        chk(start_conversion_o, 1'b1);
        clear_flag(1'b1);
        wait_flag(n0);
        chk({result_high_byte_o, result_low_byte_o}, exp_q.pop_front());
        auto_trigger_enable_i = 1'b0;
        repeat (40) @(negedge clk_i);
        chk(start_conversion_o, 1'b0);
        end_of_test();
    end

    // watchdog well beyond the several hundred cycles the sequence needs
    initial begin
        #(20000 * 10);
        error_cnt++;
        end_of_test();
    end
endmodule : tb_acc_ctrl
